// ---- chc_regs.svh ----
// Purpose: Offsets, field positions, reset values and bus constants of the charger configuration bank
// Assumes: Included by every design file that touches the bank
// Notes:   Definitions only
`ifndef CHC_REGS_SVH
`define CHC_REGS_SVH

`define CHC_DEV_ADDR          7'h6a
`define CHC_OFS_INPUT_CONTROL 8'h05
`define CHC_OFS_FAST_CHARGE   8'h06
`define CHC_OFS_INPUT_LIMIT   8'h07

`define CHC_RST_INPUT_CONTROL 8'h00
`define CHC_RST_FAST_CHARGE   8'h4a
`define CHC_RST_INPUT_LIMIT   8'h14

`define CHC_BIT_SUSPEND       0
`define CHC_BIT_MON_DIS       1
`define CHC_CTL_USED_MSB      1
`define CHC_TIMER_MSB         7
`define CHC_TIMER_LSB         5
`define CHC_CC_MSB            4
`define CHC_BIT_RESTART       6
`define CHC_IL_MSB            5

`define CHC_WP_UNLOCK         2'h3

`define CHC_CC_FLOOR_CODE     5'h05
`define CHC_CC_FLOOR_MA       11'h0fa
`define CHC_CC_STEP_MA        11'h032
`define CHC_TIMER_OFFSET_HRS  4'h3
`define CHC_IL_FLOOR_CODE     6'h09
`define CHC_IL_FLOOR_MA       11'h064
`define CHC_IL_STEP_MA        11'h019
`define CHC_IL_TOP_CODE       6'h3c
`define CHC_IL_OFF_CODE       6'h3f
`define CHC_IL_THR_PCT        18'h0005f
`define CHC_PCT_DIV           18'h00064
`define CHC_BIT_COUNT         4'h8

`endif

// ---- chc_pkg.sv ----
// Purpose: Types shared by the charger configuration bank
// Assumes: Nothing
// Notes:   One-hot serial target states
package chc_pkg;
	typedef enum logic [6:0] {
		ST_IDLE     = 7'b0000001,
		ST_ADDR     = 7'b0000010,
		ST_ADDR_ACK = 7'b0000100,
		ST_WBYTE    = 7'b0001000,
		ST_WACK     = 7'b0010000,
		ST_RBYTE    = 7'b0100000,
		ST_RACK     = 7'b1000000
	} chc_state_t;
endpackage : chc_pkg

// ---- chc_setting_decode.sv ----
// Purpose: Turns register codes into the current, timer and limit settings the analog loops use
// Assumes: Enable inputs come from logic on the same clock
// Notes:   One cycle of latency, all outputs registered
`timescale 1ns/1ps
`include "chc_regs.svh"
module chc_setting_decode import chc_pkg::*; (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	input  wire logic [4:0]  i_cc_code,
	input  wire logic [2:0]  i_timer_code,
	input  wire logic [5:0]  i_il_code,
	input  wire logic        i_charger_enabled,
	input  wire logic        i_converter_on,
	output logic      [10:0] o_charge_current_ma,
	output logic      [3:0]  o_timer_hours,
	output logic      [10:0] o_input_limit_ma,
	output logic      [10:0] o_input_limit_threshold_ma,
	output logic             o_input_limit_off
);
	function automatic logic [10:0] cc_ma(input logic [4:0] c);
		cc_ma = (c <= `CHC_CC_FLOOR_CODE) ? `CHC_CC_FLOOR_MA : 11'(c * `CHC_CC_STEP_MA);
	endfunction : cc_ma

	// Codes above the last listed step hold the top limit rather than wrap
	function automatic logic [10:0] il_ma(input logic [5:0] c);
		if (c <= `CHC_IL_FLOOR_CODE)
			il_ma = `CHC_IL_FLOOR_MA;
		else if (c >= `CHC_IL_TOP_CODE)
			il_ma = 11'(`CHC_IL_TOP_CODE * `CHC_IL_STEP_MA);
		else
			il_ma = 11'(c * `CHC_IL_STEP_MA);
	endfunction : il_ma

	logic [10:0] cc_q, cc_d, il_q, il_d, thr_q, thr_d;
	logic [3:0]  hrs_q, hrs_d;
	logic        off_q, off_d;
	logic [17:0] thr_full;

	always_comb begin
		thr_full = 18'(il_ma(i_il_code)) * `CHC_IL_THR_PCT;
		cc_d     = i_charger_enabled ? cc_ma(i_cc_code) : 11'h000;
		hrs_d    = (i_timer_code == 3'h0) ? 4'h0 : 4'({1'b0, i_timer_code}) + `CHC_TIMER_OFFSET_HRS;
		off_d    = i_converter_on && (i_il_code == `CHC_IL_OFF_CODE);
		il_d     = (i_converter_on && !off_d) ? il_ma(i_il_code) : 11'h000;
		thr_d    = (i_converter_on && !off_d) ? 11'(thr_full / `CHC_PCT_DIV) : 11'h000;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cc_q  <= 11'h000;
			hrs_q <= 4'h0;
			il_q  <= 11'h000;
			thr_q <= 11'h000;
			off_q <= 1'b0;
		end else begin
			cc_q  <= cc_d;
			hrs_q <= hrs_d;
			il_q  <= il_d;
			thr_q <= thr_d;
			off_q <= off_d;
		end
	end

	assign o_charge_current_ma        = cc_q;
	assign o_timer_hours              = hrs_q;
	assign o_input_limit_ma           = il_q;
	assign o_input_limit_threshold_ma = thr_q;
	assign o_input_limit_off          = off_q;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	AST_CC_FLOOR: assert property (i_charger_enabled && i_cc_code <= 5'h05 |=> o_charge_current_ma == 11'd250)
		else $error("charge current floor wrong");
	AST_CC_GATED: assert property (!i_charger_enabled |=> o_charge_current_ma == 11'd0)
		else $error("charge current not gated");
	AST_TIMER_OFF: assert property (i_timer_code == 3'h0 |=> o_timer_hours == 4'd0)
		else $error("timer not disabled");
	AST_TIMER_MAX: assert property (i_timer_code == 3'h7 |=> o_timer_hours == 4'd10)
		else $error("timer top wrong");
	AST_IL_FLOOR: assert property (i_converter_on && i_il_code < 6'd10 |=> o_input_limit_ma == 11'd100
		&& o_input_limit_threshold_ma == 11'd95)
		else $error("input limit floor wrong");
endmodule : chc_setting_decode

// ---- chc_config_regs.sv ----
// Purpose: Serial-bus target holding the charger input, fast-charge and input-limit configuration
// Assumes: Bus clock well below core clock; standby and safeout inputs come from another power domain
// Notes:   Pins pass two flops before use, so each bus edge is seen two core cycles late
`timescale 1ns/1ps
`include "chc_regs.svh"
// Functional notes
// - Suspend bit one enters low-current standby
// - Monitor-disable bit stops input voltage monitoring
// - Charge code gives 250mA to 1550mA
// - Charge field bits 4:0, default 500mA
// - Timer code zero disables, else 4-10 hours
// - Timer field bits 7:5, default five hours
// - Restart bit: -150mV zero, -100mV one
// - Six-bit input limit, default 500mA
// - Standby loss or power-good rise restores defaults
// - Low codes 100mA, 25mA steps, top disables
module chc_config_regs import chc_pkg::*; (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	output logic             o_sda_out,
	output logic             o_sda_oe,
	input  wire logic        i_standby_supply_valid,
	input  wire logic        i_safeout_power_good,
	input  wire logic [1:0]  i_write_protect_key,
	input  wire logic        i_charger_enabled,
	input  wire logic        i_converter_on,
	output logic             o_suspend_select,
	output logic             o_input_monitor_disable,
	output logic             o_restart_threshold_sel,
	output logic      [10:0] o_charge_current_ma,
	output logic      [3:0]  o_fast_charge_timer_hours,
	output logic      [10:0] o_input_limit_ma,
	output logic      [10:0] o_input_limit_threshold_ma,
	output logic             o_input_limit_off
);
	function automatic logic [7:0] rd_word(input logic [7:0] p, input logic [7:0] c,
		input logic [7:0] f, input logic [7:0] l);
		case (p)
			`CHC_OFS_INPUT_CONTROL: rd_word = c;
			`CHC_OFS_FAST_CHARGE:   rd_word = f;
			`CHC_OFS_INPUT_LIMIT:   rd_word = l;
			default:                rd_word = 8'h00;
		endcase
	endfunction : rd_word

	logic       scl_m, scl_q, scl_p, sda_m, sda_q, sda_p;
	logic       stby_m, stby_q, pg_m, pg_q, pg_p;
	logic       scl_rise, scl_fall, bus_start, bus_stop, pg_rise, unlocked, force_dflt;

	// Synchronisers; the first stage of each feeds only the second
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{scl_m, scl_q, scl_p} <= 3'h7;
			{sda_m, sda_q, sda_p} <= 3'h7;
			{stby_m, stby_q}      <= 2'h0;
			{pg_m, pg_q, pg_p}    <= 3'h0;
		end else begin
			{scl_m, scl_q, scl_p} <= {i_scl, scl_m, scl_q};
			{sda_m, sda_q, sda_p} <= {i_sda, sda_m, sda_q};
			{stby_m, stby_q}      <= {i_standby_supply_valid, stby_m};
			{pg_m, pg_q, pg_p}    <= {i_safeout_power_good, pg_m, pg_q};
		end
	end

	assign scl_rise   = scl_q && !scl_p;
	assign scl_fall   = !scl_q && scl_p;
	assign bus_start  = scl_q && scl_p && sda_p && !sda_q;
	assign bus_stop   = scl_q && scl_p && !sda_p && sda_q;
	assign pg_rise    = pg_q && !pg_p;
	assign force_dflt = !stby_q || pg_rise;
	assign unlocked   = (i_write_protect_key == `CHC_WP_UNLOCK);

	chc_state_t st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sr_q, sr_d, tx_q, tx_d, ptr_q, ptr_d, rdv;
	logic       pph_q, pph_d, rw_q, rw_d, oe_q, oe_d, nack_q, nack_d, wr_en;
	logic [7:0] ctl_q, ctl_d, fcc_q, fcc_d, ilc_q, ilc_d;

	always_comb begin
		rdv    = rd_word(ptr_q, ctl_q, fcc_q, ilc_q);
		st_d   = st_q;
		cnt_d  = cnt_q;
		sr_d   = sr_q;
		tx_d   = tx_q;
		ptr_d  = ptr_q;
		pph_d  = pph_q;
		rw_d   = rw_q;
		oe_d   = oe_q;
		nack_d = nack_q;
		wr_en  = 1'b0;
		if (bus_stop) begin
			st_d = ST_IDLE;
			oe_d = 1'b0;
		end else if (bus_start) begin
			st_d  = ST_ADDR;
			cnt_d = 4'h0;
			pph_d = 1'b1;
			oe_d  = 1'b0;
		end else begin
			case (st_q)
				ST_ADDR, ST_WBYTE: begin
					if (scl_rise && cnt_q != `CHC_BIT_COUNT) begin
						sr_d  = {sr_q[6:0], sda_q};
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == `CHC_BIT_COUNT) begin
						if (st_q == ST_ADDR) begin
							// Other targets' traffic is ignored until the next start
							if (sr_q[7:1] == `CHC_DEV_ADDR) begin
								oe_d = 1'b1;
								rw_d = sr_q[0];
								st_d = ST_ADDR_ACK;
							end else begin
								st_d = ST_IDLE;
							end
						end else begin
							oe_d = 1'b1;
							st_d = ST_WACK;
							if (pph_q) begin
								ptr_d = sr_q;
								pph_d = 1'b0;
							end else begin
								wr_en = 1'b1;
								ptr_d = ptr_q + 8'h01;
							end
						end
					end
				end
				ST_ADDR_ACK, ST_WACK: begin
					if (scl_fall) begin
						cnt_d = 4'h0;
						if (st_q == ST_ADDR_ACK && rw_q) begin
							tx_d  = rdv;
							ptr_d = ptr_q + 8'h01;
							oe_d  = !rdv[7];
							st_d  = ST_RBYTE;
						end else begin
							oe_d = 1'b0;
							st_d = ST_WBYTE;
						end
					end
				end
				ST_RBYTE: begin
					if (scl_rise) begin
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall) begin
						if (cnt_q == `CHC_BIT_COUNT) begin
							oe_d = 1'b0;
							st_d = ST_RACK;
						end else begin
							tx_d = {tx_q[6:0], 1'b0};
							oe_d = !tx_q[6];
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						nack_d = sda_q;
					end else if (scl_fall) begin
						if (nack_q) begin
							st_d = ST_IDLE;
						end else begin
							tx_d  = rdv;
							ptr_d = ptr_q + 8'h01;
							oe_d  = !rdv[7];
							cnt_d = 4'h0;
							st_d  = ST_RBYTE;
						end
					end
				end
				default: begin
					st_d = ST_IDLE;
					oe_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q   <= ST_IDLE;
			cnt_q  <= 4'h0;
			sr_q   <= 8'h00;
			tx_q   <= 8'h00;
			ptr_q  <= 8'h00;
			pph_q  <= 1'b0;
			rw_q   <= 1'b0;
			oe_q   <= 1'b0;
			nack_q <= 1'b0;
		end else begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			sr_q   <= sr_d;
			tx_q   <= tx_d;
			ptr_q  <= ptr_d;
			pph_q  <= pph_d;
			rw_q   <= rw_d;
			oe_q   <= oe_d;
			nack_q <= nack_d;
		end
	end

	// Power events override a write landing in the same cycle
	always_comb begin
		ctl_d = ctl_q;
		fcc_d = fcc_q;
		ilc_d = ilc_q;
		if (wr_en) begin
			case (ptr_q)
				`CHC_OFS_INPUT_CONTROL: ctl_d = {6'h00, sr_q[`CHC_CTL_USED_MSB:0]};
				`CHC_OFS_FAST_CHARGE: if (unlocked) fcc_d = sr_q;
				`CHC_OFS_INPUT_LIMIT: if (unlocked) ilc_d = {1'b0, sr_q[6:0]};
				default: ;
			endcase
		end
		if (force_dflt) begin
			ctl_d = `CHC_RST_INPUT_CONTROL;
			fcc_d = `CHC_RST_FAST_CHARGE;
			ilc_d = `CHC_RST_INPUT_LIMIT;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctl_q <= `CHC_RST_INPUT_CONTROL;
			fcc_q <= `CHC_RST_FAST_CHARGE;
			ilc_q <= `CHC_RST_INPUT_LIMIT;
		end else begin
			ctl_q <= ctl_d;
			fcc_q <= fcc_d;
			ilc_q <= ilc_d;
		end
	end

	assign o_sda_out               = 1'b0;
	assign o_sda_oe                = oe_q;
	assign o_suspend_select        = ctl_q[`CHC_BIT_SUSPEND];
	assign o_input_monitor_disable = ctl_q[`CHC_BIT_MON_DIS];
	assign o_restart_threshold_sel = ilc_q[`CHC_BIT_RESTART];

	chc_setting_decode u_decode (
		.i_core_clk                 (i_core_clk),
		.i_rst_n                    (i_rst_n),
		.i_cc_code                  (fcc_q[`CHC_CC_MSB:0]),
		.i_timer_code               (fcc_q[`CHC_TIMER_MSB:`CHC_TIMER_LSB]),
		.i_il_code                  (ilc_q[`CHC_IL_MSB:0]),
		.i_charger_enabled          (i_charger_enabled),
		.i_converter_on             (i_converter_on),
		.o_charge_current_ma        (o_charge_current_ma),
		.o_timer_hours              (o_fast_charge_timer_hours),
		.o_input_limit_ma           (o_input_limit_ma),
		.o_input_limit_threshold_ma (o_input_limit_threshold_ma),
		.o_input_limit_off          (o_input_limit_off)
	);

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_ctl_write;
		wr_en && ptr_q == 8'h05 && !force_dflt;
	endsequence
	sequence s_locked_write;
		wr_en && (ptr_q == 8'h06 || ptr_q == 8'h07) && !unlocked && !force_dflt;
	endsequence
	sequence s_addr_hit;
		st_q == ST_ADDR && !bus_start && !bus_stop && scl_fall && cnt_q == 4'h8 && sr_q[7:1] == 7'h6a;
	endsequence

	AST_SUSPEND_SET: assert property (s_ctl_write |=> o_suspend_select == $past(sr_q[0]))
		else $error("suspend bit not taken");
	AST_MON_DIS_SET: assert property (s_ctl_write |=> o_input_monitor_disable == $past(sr_q[1]))
		else $error("monitor disable not taken");
	AST_LOCKED: assert property (s_locked_write |=> $stable(fcc_q) && $stable(ilc_q))
		else $error("protected write accepted");
	AST_STBY_DFLT: assert property (!stby_q |=> fcc_q == 8'h4a && ilc_q == 8'h14 && !o_restart_threshold_sel)
		else $error("defaults not held on standby loss");
	AST_PG_DFLT: assert property ($rose(pg_q) |=> fcc_q[7:5] == 3'h2 && fcc_q[4:0] == 5'h0a && ilc_q[5:0] == 6'h14)
		else $error("defaults not restored on power-good rise");
	AST_UPPER_ZERO: assert property (ctl_q[7:2] == 6'h00 && ilc_q[7] == 1'b0)
		else $error("unused bits set");
	AST_ADDR_ACK: assert property (s_addr_hit |=> o_sda_oe && st_q == ST_ADDR_ACK)
		else $error("address not acknowledged");
	AST_DFLT_DECODE: assert property (!stby_q && i_charger_enabled ##1 i_charger_enabled |=> o_charge_current_ma == 11'd500
		&& o_fast_charge_timer_hours == 4'd5)
		else $error("default decode wrong");
endmodule : chc_config_regs

// ---- chc_host_model.sv ----
// Purpose: Serial bus controller model that reads and writes the configuration bank
// Assumes: The bench resolves the open-drain data line with a pull-up
// Notes:   Every data-bit phase lasts 10 core cycles, above the 8 the target needs
`timescale 1ns/1ps
`include "chc_regs.svh"
module chc_host_model (
	input  wire logic i_core_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_low
);
	initial begin
		o_scl     = 1'b1;
		o_sda_low = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask : tick

	// Data moves only in the middle of the low phase, so it never looks like a frame edge
	task automatic bus_bit(input logic b, output logic r);
		tick(5);
		o_sda_low = ~b;
		tick(5);
		o_scl = 1'b1;
		tick(5);
		r = i_sda;
		tick(5);
		o_scl = 1'b0;
	endtask : bus_bit

	task automatic bus_start;
		o_sda_low = 1'b0;
		tick(5);
		o_scl = 1'b1;
		tick(10);
		o_sda_low = 1'b1;
		tick(10);
		o_scl = 1'b0;
	endtask : bus_start

	task automatic bus_stop;
		tick(5);
		o_sda_low = 1'b1;
		tick(5);
		o_scl = 1'b1;
		tick(10);
		o_sda_low = 1'b0;
		tick(10);
	endtask : bus_stop

	// Returns the ninth bit: low means the byte was acknowledged
	task automatic bus_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bus_bit(tx[i], rx[i]);
		end
		bus_bit(ack_in, ack);
	endtask : bus_byte

	task automatic reg_write(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] data, output logic nack);
		logic [7:0] rx;
		logic       a0;
		logic       a1;
		logic       a2;
		bus_start();
		bus_byte({dev, 1'b0}, 1'b1, rx, a0);
		bus_byte(ofs, 1'b1, rx, a1);
		bus_byte(data, 1'b1, rx, a2);
		bus_stop();
		nack = a0 | a1 | a2;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] ofs, output logic [7:0] data);
		logic a;
		bus_start();
		bus_byte({`CHC_DEV_ADDR, 1'b0}, 1'b1, data, a);
		bus_byte(ofs, 1'b1, data, a);
		bus_start();
		bus_byte({`CHC_DEV_ADDR, 1'b1}, 1'b1, data, a);
		bus_byte(8'hff, 1'b1, data, a);
		bus_stop();
	endtask : reg_read
endmodule : chc_host_model

// ---- test_chc_config_regs.sv ----
// Purpose: Self-checking bench for the charger configuration bank
// Assumes: Bus traffic starts well after reset release
// Notes:   Expected settings are computed here from the code tables
`timescale 1ns/1ps
`include "chc_regs.svh"
module test_chc_config_regs;
	logic        i_core_clk;
	logic        i_rst_n;
	logic        i_standby_supply_valid;
	logic        i_safeout_power_good;
	logic [1:0]  i_write_protect_key;
	logic        i_charger_enabled;
	logic        i_converter_on;
	logic        scl;
	logic        host_low;
	logic        sda_line;
	logic        o_sda_out;
	logic        o_sda_oe;
	logic        o_suspend_select;
	logic        o_input_monitor_disable;
	logic        o_restart_threshold_sel;
	logic [10:0] o_charge_current_ma;
	logic [3:0]  o_fast_charge_timer_hours;
	logic [10:0] o_input_limit_ma;
	logic [10:0] o_input_limit_threshold_ma;
	logic        o_input_limit_off;
	int          failures;
	int          checks;

	// Pull-up: the line is low only while some party pulls it
	assign sda_line = ~(host_low | (o_sda_oe & ~o_sda_out));

	chc_config_regs u_chc_config_regs (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda_line),
		.o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_standby_supply_valid(i_standby_supply_valid),
		.i_safeout_power_good(i_safeout_power_good), .i_write_protect_key(i_write_protect_key),
		.i_charger_enabled(i_charger_enabled), .i_converter_on(i_converter_on),
		.o_suspend_select(o_suspend_select), .o_input_monitor_disable(o_input_monitor_disable),
		.o_restart_threshold_sel(o_restart_threshold_sel), .o_charge_current_ma(o_charge_current_ma),
		.o_fast_charge_timer_hours(o_fast_charge_timer_hours), .o_input_limit_ma(o_input_limit_ma),
		.o_input_limit_threshold_ma(o_input_limit_threshold_ma), .o_input_limit_off(o_input_limit_off));

	chc_host_model u_chc_host_model (.i_core_clk(i_core_clk), .i_sda(sda_line), .o_scl(scl), .o_sda_low(host_low));

	always #2 i_core_clk = ~i_core_clk;

	task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] ofs, input logic [7:0] data);
		logic nack;
		u_chc_host_model.reg_write(`CHC_DEV_ADDR, ofs, data, nack);
		check("ack", 11'(nack), 11'h0);
	endtask : wr

	task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
		logic [7:0] d;
		u_chc_host_model.reg_read(ofs, d);
		check("read", 11'(d), 11'(exp));
	endtask : rd_chk

	task automatic test_defaults;
		rd_chk(8'h05, 8'h00);
		rd_chk(8'h06, 8'h4a);
		rd_chk(8'h07, 8'h14);
		check("cc ma", o_charge_current_ma, 11'h1f4);
		check("timer", 11'(o_fast_charge_timer_hours), 11'h5);
		check("il ma", o_input_limit_ma, 11'h1f4);
		check("il thr", o_input_limit_threshold_ma, 11'h1db);
		check("restart", 11'(o_restart_threshold_sel), 11'h0);
		$display("test defaults done");
	endtask : test_defaults

	// Key stays locked: the control register must still take writes
	task automatic test_control;
		logic [1:0] v;
		for (int i = 0; i < 4; i++) begin
			v = 2'(i);
			wr(8'h05, {6'h3f, v});
			check("suspend", 11'(o_suspend_select), 11'(v[0]));
			check("mon dis", 11'(o_input_monitor_disable), 11'(v[1]));
			rd_chk(8'h05, {6'h00, v});
		end
		// Every key value short of the unlock code must keep both protected registers
		for (int k = 0; k < 3; k++) begin
			i_write_protect_key = 2'(k);
			wr(8'h06, 8'h00);
			wr(8'h07, 8'h3f);
			rd_chk(8'h06, 8'h4a);
			rd_chk(8'h07, 8'h14);
		end
		$display("test control done");
	endtask : test_control

	task automatic test_charge;
		logic [4:0] cc;
		i_write_protect_key = `CHC_WP_UNLOCK;
		for (int t = 0; t < 8; t++) begin
			cc = 5'(t * 4 + 3);
			wr(8'h06, {3'(t), cc});
			check("cc ma", o_charge_current_ma, 11'(cc <= 5 ? 250 : 250 + (cc - 5) * 50));
			check("timer", 11'(o_fast_charge_timer_hours), 11'(t == 0 ? 0 : t + 3));
		end
		i_charger_enabled = 1'b0;
		u_chc_host_model.tick(4);
		check("cc off", o_charge_current_ma, 11'h0);
		i_charger_enabled = 1'b1;
		$display("test charge done");
	endtask : test_charge

	task automatic test_limit;
		logic [5:0] codes [7] = '{6'h00, 6'h09, 6'h0a, 6'h14, 6'h3c, 6'h3d, 6'h3f};
		logic [5:0] c;
		int         ma;
		for (int k = 0; k < 7; k++) begin
			c  = codes[k];
			ma = c == 63 ? 0 : c <= 9 ? 100 : c >= 60 ? 1500 : 250 + (c - 10) * 25;
			wr(8'h07, {1'b1, k[0], c});
			rd_chk(8'h07, {1'b0, k[0], c});
			check("restart", 11'(o_restart_threshold_sel), 11'(k[0]));
			check("il ma", o_input_limit_ma, 11'(ma));
			check("il thr", o_input_limit_threshold_ma, 11'(ma * 95 / 100));
			check("il off", 11'(o_input_limit_off), 11'(c == 63));
		end
		wr(8'h07, 8'h20);
		i_converter_on = 1'b0;
		u_chc_host_model.tick(4);
		check("il conv off", o_input_limit_ma, 11'h0);
		i_converter_on = 1'b1;
		$display("test limit done");
	endtask : test_limit

	task automatic test_power;
		logic nack;
		for (int p = 0; p < 2; p++) begin
			wr(8'h06, 8'h1f);
			wr(8'h07, 8'h7f);
			if (p == 0) i_standby_supply_valid = 1'b0;
			else i_safeout_power_good = 1'b1;
			u_chc_host_model.tick(6);
			i_standby_supply_valid = 1'b1;
			u_chc_host_model.tick(6);
			rd_chk(8'h06, 8'h4a);
			rd_chk(8'h07, 8'h14);
		end
		i_safeout_power_good = 1'b0;
		u_chc_host_model.reg_write(`CHC_DEV_ADDR ^ 7'h01, 8'h06, 8'h00, nack);
		check("wrong dev", 11'(nack), 11'h1);
		rd_chk(8'h06, 8'h4a);
		rd_chk(8'h10, 8'h00);
		$display("test power done");
	endtask : test_power

	// A reset in mid-run must drop the control and fast-charge registers and their settings back to their defaults
	task automatic test_reset;
		wr(8'h05, 8'h03);
		wr(8'h06, 8'h1f);
		check("suspend set", 11'(o_suspend_select), 11'h1);
		check("cc set", o_charge_current_ma, 11'h60e);
		u_chc_host_model.tick(2);
		i_rst_n = 1'b0;
		u_chc_host_model.tick(2);
		check("oe in reset", 11'(o_sda_oe), 11'h0);
		i_rst_n = 1'b1;
		u_chc_host_model.tick(4);
		check("suspend", 11'(o_suspend_select), 11'h0);
		check("mon dis", 11'(o_input_monitor_disable), 11'h0);
		check("cc ma", o_charge_current_ma, 11'h1f4);
		check("timer", 11'(o_fast_charge_timer_hours), 11'h5);
		check("sda out", 11'(o_sda_out), 11'h0);
		check("sda oe", 11'(o_sda_oe), 11'h0);
		rd_chk(8'h05, 8'h00);
		rd_chk(8'h06, 8'h4a);
		$display("test reset done");
	endtask : test_reset

	task automatic final_report;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report

	// The full run takes roughly 45k cycles; the limit leaves margin but stays well short of 100k
	initial begin
		#300_000;
		failures++;
		final_report();
	end

	initial begin
		i_core_clk             = 1'b0;
		i_rst_n                = 1'b0;
		i_standby_supply_valid = 1'b1;
		i_safeout_power_good   = 1'b0;
		i_write_protect_key    = 2'h0;
		i_charger_enabled      = 1'b1;
		i_converter_on         = 1'b1;
		failures               = 0;
		checks                 = 0;
		u_chc_host_model.tick(2);
		i_rst_n = 1'b1;
		u_chc_host_model.tick(10);
		test_defaults();
		test_control();
		test_charge();
		test_limit();
		test_power();
		test_reset();
		final_report();
	end
endmodule : test_chc_config_regs
